// ===== rx_consts.svh
`ifndef RX_CONSTS_SVH
`define RX_CONSTS_SVH

// ----------------------------------------
// datapath widths and storage
// ----------------------------------------
`define RX_NREG 30
`define RX_PC_RST 32'h0000_0000
`define RX_ZERO 32'h0000_0000
`define RX_WSTEP 32'h0000_0004
`define RX_HSTEP 32'h0000_0002
`define RX_WMASK 32'hffff_fffc
`define RX_HMASK 32'hffff_fffe

// ----------------------------------------
// logical register numbers
// ----------------------------------------
`define RX_FIQ_LO 4'h8
`define RX_SP_IDX 4'hd
`define RX_LR_IDX 4'he
`define RX_PC_IDX 4'hf

// ----------------------------------------
// banked storage bases
// ----------------------------------------
`define RX_FIQ_BASE 5'h0f
`define RX_SVC_BASE 5'h16
`define RX_ABT_BASE 5'h18
`define RX_IRQ_BASE 5'h1a
`define RX_UND_BASE 5'h1c

// ----------------------------------------
// operating mode codes
// ----------------------------------------
`define RX_M_USR 3'h0
`define RX_M_FIQ 3'h1
`define RX_M_IRQ 3'h2
`define RX_M_SVC 3'h3
`define RX_M_ABT 3'h4
`define RX_M_SYS 3'h5
`define RX_M_UND 3'h6

// ----------------------------------------
// multiplier stepping
// ----------------------------------------
`define RX_MSTEP 6'h08
`define RX_MRES_SH 24'h00_0000

`endif

// ===== rx_pkg.sv
package rx_pkg;

`include "rx_consts.svh"

typedef enum logic [2:0] {
    RX_MODE_USR = `RX_M_USR,
    RX_MODE_FIQ = `RX_M_FIQ,
    RX_MODE_IRQ = `RX_M_IRQ,
    RX_MODE_SVC = `RX_M_SVC,
    RX_MODE_ABT = `RX_M_ABT,
    RX_MODE_SYS = `RX_M_SYS,
    RX_MODE_UND = `RX_M_UND
} rx_mode_e;

typedef enum logic [3:0] {
    RX_EQ, RX_NE, RX_CS, RX_CC, RX_MI, RX_PL, RX_VS, RX_VC,
    RX_HI, RX_LS, RX_GE, RX_LT, RX_GT, RX_LE, RX_AL, RX_NV
} rx_cond_e;

typedef enum logic [3:0] {
    RX_AND, RX_EOR, RX_SUB, RX_RSB, RX_ADD, RX_ADC, RX_SBC, RX_RSC,
    RX_TST, RX_TEQ, RX_CMP, RX_CMN, RX_ORR, RX_MOV, RX_BIC, RX_MVN
} rx_aluop_e;

typedef enum logic [2:0] {
    RX_CL_ALU, RX_CL_MUL, RX_CL_LDM, RX_CL_STM,
    RX_CL_MODE, RX_CL_STATE, RX_CL_UNDEF
} rx_class_e;

typedef enum logic [1:0] {
    RX_SH_LSL, RX_SH_LSR, RX_SH_ASR, RX_SH_ROR
} rx_shift_e;

typedef enum logic [1:0] {
    RX_ST_IDLE = 2'b00,
    RX_ST_MUL = 2'b01,
    RX_ST_MULX = 2'b11,
    RX_ST_LSM = 2'b10
} rx_state_e;

endpackage

// ===== rx_core_exec.sv
`timescale 1ns/1ps
`include "rx_consts.svh"
module rx_core_exec
    import rx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ex_valid,
    input wire rx_class_e ex_class,
    input wire rx_cond_e ex_cond,
    input wire rx_aluop_e ex_op,
    input wire logic ex_set_flags,
    input wire logic [3:0] ex_rd,
    input wire logic [3:0] ex_rn,
    input wire logic [3:0] ex_rm,
    input wire logic [3:0] ex_rs,
    input wire rx_shift_e ex_sh_type,
    input wire logic [4:0] ex_sh_amt,
    input wire logic ex_mul_long,
    input wire logic ex_mul_acc,
    input wire logic [15:0] ex_reglist,
    input wire logic ex_wback,
    input wire rx_mode_e ex_new_mode,
    input wire logic irq_req,
    input wire logic fiq_req,
    input wire logic abort_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic ex_ready_reg,
    output logic ex_done_reg,
    output logic ex_skip_reg,
    output logic [31:0] program_counter_register,
    output rx_mode_e mode_reg,
    output logic compact_state_reg,
    output logic priv_reg,
    output logic [3:0] flags_reg,
    output logic mem_req_reg,
    output logic mem_we_reg,
    output logic [31:0] mem_addr_reg,
    output logic [31:0] mem_wdata_reg
);

// ----------------------------------------
// state
// ----------------------------------------
logic [31:0] rf_reg [0:`RX_NREG-1];
rx_state_e st_reg, st_next;
logic [31:0] mcand_reg, mplier_reg;
logic [63:0] prod_reg, prod_next;
logic [5:0] msh_reg;
logic [1:0] xtra_reg;
logic mlong_reg, pcl_reg, lsm_ld_reg, wback_reg;
logic [3:0] mrd_reg, mhi_reg, base_reg;
logic [15:0] list_reg, list_next;
logic [31:0] addr_reg, addr_next;
logic [31:0] rn_val, rm_val, rs_val, rd_val, st_val;
logic [3:0] low_cur, low_next;
logic pass, take, retire, skip, exc, flag_we, mode_we, mul_start, pc_set, compact_next;
rx_mode_e exc_m;
logic [31:0] pc_val, pc_step;
logic wa_en, wb_en;
logic [3:0] wa_r, wb_r;
rx_mode_e wa_m;
logic [31:0] wa_d, wb_d;
logic [31:0] op2, alu_res, ax, ay;
logic sh_c, acin, alu_c, alu_v, alu_wr, arith;
logic [32:0] asum;

// ----------------------------------------
// helpers
// ----------------------------------------
function automatic logic [4:0] phys(input rx_mode_e m, input logic [3:0] r);
    logic [4:0] p;
    p = {1'b0, r};
    if (m == RX_MODE_FIQ && r >= `RX_FIQ_LO) begin
        p = `RX_FIQ_BASE + {1'b0, r - `RX_FIQ_LO};
    end else if (r >= `RX_SP_IDX) begin
        unique case (m)
            RX_MODE_SVC: p = `RX_SVC_BASE + {4'h0, r[0]};
            RX_MODE_ABT: p = `RX_ABT_BASE + {4'h0, r[0]};
            RX_MODE_IRQ: p = `RX_IRQ_BASE + {4'h0, r[0]};
            RX_MODE_UND: p = `RX_UND_BASE + {4'h0, r[0]};
            default: p = {1'b0, r};
        endcase
    end
    return p;
endfunction

function automatic logic [3:0] lowest(input logic [15:0] l);
    logic [3:0] k;
    k = 4'h0;
    for (int i = 15; i >= 0; i--) begin
        if (l[i]) k = 4'(i);
    end
    return k;
endfunction

function automatic logic cond_ok(input rx_cond_e c, input logic [3:0] f);
    logic n, z, cf, v;
    {n, z, cf, v} = f;
    unique case (c)
        RX_EQ: return z;
        RX_NE: return !z;
        RX_CS: return cf;
        RX_CC: return !cf;
        RX_MI: return n;
        RX_PL: return !n;
        RX_VS: return v;
        RX_VC: return !v;
        RX_HI: return cf && !z;
        RX_LS: return !cf || z;
        RX_GE: return n == v;
        RX_LT: return n != v;
        RX_GT: return !z && (n == v);
        RX_LE: return z || (n != v);
        RX_AL: return 1'b1;
        RX_NV: return 1'b0;
    endcase
endfunction

// the pc index reads the pc, every other number goes through the bank map
always_comb begin
    rn_val = (ex_rn == `RX_PC_IDX) ? program_counter_register : rf_reg[phys(mode_reg, ex_rn)];
    rm_val = (ex_rm == `RX_PC_IDX) ? program_counter_register : rf_reg[phys(mode_reg, ex_rm)];
    rs_val = (ex_rs == `RX_PC_IDX) ? program_counter_register : rf_reg[phys(mode_reg, ex_rs)];
    rd_val = (ex_rd == `RX_PC_IDX) ? program_counter_register : rf_reg[phys(mode_reg, ex_rd)];
    st_val = (low_next == `RX_PC_IDX) ? program_counter_register : rf_reg[phys(mode_reg, low_next)];
end

// ----------------------------------------
// barrel shifter and alu
// ----------------------------------------
always_comb begin
    logic [32:0] t;
    t = {1'b0, rm_val};
    op2 = rm_val;
    sh_c = flags_reg[1];
    if (ex_sh_amt != 5'h00) begin
        unique case (ex_sh_type)
            RX_SH_LSL: begin
                t = {1'b0, rm_val} << ex_sh_amt;
                {sh_c, op2} = t;
            end
            RX_SH_LSR: begin
                t = {rm_val, 1'b0} >> ex_sh_amt;
                {op2, sh_c} = t;
            end
            RX_SH_ASR: begin
                t = 33'($signed({rm_val, 1'b0}) >>> ex_sh_amt);
                {op2, sh_c} = t;
            end
            RX_SH_ROR: begin
                op2 = 32'({rm_val, rm_val} >> ex_sh_amt);
                sh_c = op2[31];
            end
        endcase
    end
end

always_comb begin
    ax = rn_val;
    ay = op2;
    acin = 1'b0;
    arith = 1'b1;
    alu_wr = 1'b1;
    unique case (ex_op)
        RX_SUB, RX_CMP: begin
            ay = ~op2;
            acin = 1'b1;
        end
        RX_RSB: begin
            ax = op2;
            ay = ~rn_val;
            acin = 1'b1;
        end
        RX_ADC: acin = flags_reg[1];
        RX_SBC: begin
            ay = ~op2;
            acin = flags_reg[1];
        end
        RX_RSC: begin
            ax = op2;
            ay = ~rn_val;
            acin = flags_reg[1];
        end
        RX_ADD, RX_CMN: ;
        default: arith = 1'b0;
    endcase
    asum = {1'b0, ax} + {1'b0, ay} + {32'h0, acin};
    unique case (ex_op)
        RX_AND, RX_TST: alu_res = rn_val & op2;
        RX_EOR, RX_TEQ: alu_res = rn_val ^ op2;
        RX_ORR: alu_res = rn_val | op2;
        RX_MOV: alu_res = op2;
        RX_BIC: alu_res = rn_val & ~op2;
        RX_MVN: alu_res = ~op2;
        default: alu_res = asum[31:0];
    endcase
    if (ex_op == RX_TST || ex_op == RX_TEQ || ex_op == RX_CMP || ex_op == RX_CMN) begin
        alu_wr = 1'b0;
    end
    alu_c = arith ? asum[32] : sh_c;
    alu_v = arith ? ((ax[31] == ay[31]) && (asum[31] != ax[31])) : flags_reg[0];
end

// ----------------------------------------
// sequencing
// ----------------------------------------
assign pass = cond_ok(ex_cond, flags_reg);
assign pc_step = program_counter_register + (compact_state_reg ? `RX_HSTEP : `RX_WSTEP);
assign low_cur = lowest(list_reg);
// each 8-bit slice of the multiplier is one pass through the 32x8 array
assign prod_next = prod_reg + (({32'h0, mcand_reg} * {56'h0, mplier_reg[7:0]}) << msh_reg);

always_comb begin
    st_next = st_reg;
    take = 1'b0;
    retire = 1'b0;
    skip = 1'b0;
    exc = 1'b0;
    exc_m = mode_reg;
    flag_we = 1'b0;
    mode_we = 1'b0;
    mul_start = 1'b0;
    pc_set = 1'b0;
    pc_val = alu_res & `RX_WMASK;
    compact_next = compact_state_reg;
    wa_en = 1'b0;
    wa_r = ex_rd;
    wa_m = mode_reg;
    wa_d = alu_res;
    wb_en = 1'b0;
    wb_r = mhi_reg;
    wb_d = prod_next[63:32];
    list_next = list_reg;
    addr_next = addr_reg;
    unique case (st_reg)
        RX_ST_IDLE: begin
            if (abort_req) begin
                exc = 1'b1;
                exc_m = RX_MODE_ABT;
            end else if (fiq_req) begin
                exc = 1'b1;
                exc_m = RX_MODE_FIQ;
            end else if (irq_req) begin
                exc = 1'b1;
                exc_m = RX_MODE_IRQ;
            end else if (ex_valid && ex_ready_reg) begin
                take = 1'b1;
                if (!pass) begin
                    skip = 1'b1;
                    retire = 1'b1;
                end else begin
                    unique case (ex_class)
                        RX_CL_ALU: begin
                            retire = 1'b1;
                            flag_we = ex_set_flags;
                            wa_en = alu_wr && (ex_rd != `RX_PC_IDX);
                            pc_set = alu_wr && (ex_rd == `RX_PC_IDX);
                            pc_val = alu_res & (compact_state_reg ? `RX_HMASK : `RX_WMASK);
                        end
                        RX_CL_MUL: begin
                            mul_start = 1'b1;
                            st_next = RX_ST_MUL;
                        end
                        RX_CL_LDM, RX_CL_STM: begin
                            list_next = ex_reglist;
                            addr_next = rn_val;
                            st_next = RX_ST_LSM;
                        end
                        RX_CL_MODE: begin
                            retire = 1'b1;
                            mode_we = (mode_reg != RX_MODE_USR);
                        end
                        RX_CL_STATE: begin
                            retire = 1'b1;
                            pc_set = 1'b1;
                            compact_next = rm_val[0];
                            pc_val = rm_val & (rm_val[0] ? `RX_HMASK : `RX_WMASK);
                        end
                        default: begin
                            take = 1'b0;
                            exc = 1'b1;
                            exc_m = RX_MODE_UND;
                        end
                    endcase
                end
            end
        end
        RX_ST_MUL: begin
            // stop once the multiplier bits above the current 8-bit slice are all zero
            if (mplier_reg[31:8] == `RX_MRES_SH) begin
                if (xtra_reg == 2'h0) begin
                    st_next = RX_ST_IDLE;
                    retire = 1'b1;
                    wa_en = (mrd_reg != `RX_PC_IDX);
                    wa_r = mrd_reg;
                    wa_d = prod_next[31:0];
                end else begin
                    st_next = RX_ST_MULX;
                end
            end
        end
        RX_ST_MULX: begin
            if (xtra_reg == 2'h1) begin
                st_next = RX_ST_IDLE;
                retire = 1'b1;
                wa_en = (mrd_reg != `RX_PC_IDX);
                wa_r = mrd_reg;
                wa_d = prod_reg[31:0];
                wb_en = mlong_reg && (mhi_reg != `RX_PC_IDX);
                wb_d = prod_reg[63:32];
            end
        end
        RX_ST_LSM: begin
            if (abort_req) begin
                exc = 1'b1;
                exc_m = RX_MODE_ABT;
                st_next = RX_ST_IDLE;
            end else if (list_reg == 16'h0000) begin
                st_next = RX_ST_IDLE;
                retire = 1'b1;
                wb_en = wback_reg && (base_reg != `RX_PC_IDX);
                wb_r = base_reg;
                wb_d = addr_reg;
            end else if (mem_req_reg && mem_ack) begin
                list_next = list_reg & ~(16'h0001 << low_cur);
                addr_next = addr_reg + `RX_WSTEP;
                wa_en = lsm_ld_reg && (low_cur != `RX_PC_IDX);
                wa_r = low_cur;
                wa_d = mem_rdata;
                pc_set = lsm_ld_reg && (low_cur == `RX_PC_IDX);
                pc_val = mem_rdata & `RX_WMASK;
            end
        end
    endcase
    if (exc) begin
        // return address goes to the link register of the mode being entered
        wa_en = 1'b1;
        wa_r = `RX_LR_IDX;
        wa_m = exc_m;
        wa_d = program_counter_register;
        // wide state is entered, so a halfword pc bit must not survive
        pc_set = 1'b1;
        pc_val = program_counter_register & `RX_WMASK;
    end
end

assign low_next = lowest(list_next);

// ----------------------------------------
// register file, one entry per generate step
// ----------------------------------------
for (genvar gi = 0; gi < `RX_NREG; gi++) begin : g_rf
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rf_reg[gi] <= `RX_ZERO;
        end else if (wa_en && phys(wa_m, wa_r) == 5'(gi)) begin
            rf_reg[gi] <= wa_d;
        end else if (wb_en && phys(mode_reg, wb_r) == 5'(gi)) begin
            rf_reg[gi] <= wb_d;
        end
    end
end

// ----------------------------------------
// control and status flops
// ----------------------------------------
always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        st_reg <= RX_ST_IDLE;
        ex_ready_reg <= 1'b0;
        ex_done_reg <= 1'b0;
        ex_skip_reg <= 1'b0;
    end else begin
        st_reg <= st_next;
        ex_ready_reg <= (st_next == RX_ST_IDLE);
        ex_done_reg <= retire;
        ex_skip_reg <= skip;
    end
end

always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        program_counter_register <= `RX_PC_RST;
        compact_state_reg <= 1'b0;
        pcl_reg <= 1'b0;
    end else begin
        if (pc_set) begin
            program_counter_register <= pc_val;
        end else if (retire && !pcl_reg) begin
            program_counter_register <= pc_step;
        end
        compact_state_reg <= exc ? 1'b0 : compact_next;
        pcl_reg <= (st_next == RX_ST_LSM) && (pcl_reg || pc_set);
    end
end

always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        mode_reg <= RX_MODE_SVC;
        priv_reg <= 1'b1;
    end else if (exc) begin
        mode_reg <= exc_m;
        priv_reg <= 1'b1;
    end else if (mode_we) begin
        mode_reg <= ex_new_mode;
        priv_reg <= (ex_new_mode != RX_MODE_USR);
    end
end

always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        flags_reg <= 4'h0;
    end else if (flag_we) begin
        flags_reg <= {alu_res[31], alu_res == `RX_ZERO, alu_c, alu_v};
    end
end

// ----------------------------------------
// multiplier
// ----------------------------------------
always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        mcand_reg <= `RX_ZERO;
        mplier_reg <= `RX_ZERO;
        prod_reg <= 64'h0000_0000_0000_0000;
        msh_reg <= 6'h00;
        xtra_reg <= 2'h0;
        mlong_reg <= 1'b0;
        mrd_reg <= 4'h0;
        mhi_reg <= 4'h0;
    end else if (mul_start) begin
        mcand_reg <= rm_val;
        mplier_reg <= rs_val;
        prod_reg <= ex_mul_acc ? (ex_mul_long ? {rn_val, rd_val} : {32'h0, rn_val}) : 64'h0;
        msh_reg <= 6'h00;
        xtra_reg <= {1'b0, ex_mul_long} + {1'b0, ex_mul_acc};
        mlong_reg <= ex_mul_long;
        mrd_reg <= ex_rd;
        mhi_reg <= ex_rn;
    end else if (st_reg == RX_ST_MUL) begin
        prod_reg <= prod_next;
        mplier_reg <= mplier_reg >> `RX_MSTEP;
        msh_reg <= msh_reg + `RX_MSTEP;
    end else if (st_reg == RX_ST_MULX) begin
        xtra_reg <= xtra_reg - 2'h1;
    end
end

// ----------------------------------------
// load and store multiple
// ----------------------------------------
always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        list_reg <= 16'h0000;
        addr_reg <= `RX_ZERO;
        lsm_ld_reg <= 1'b0;
        wback_reg <= 1'b0;
        base_reg <= 4'h0;
        mem_req_reg <= 1'b0;
        mem_we_reg <= 1'b0;
        mem_addr_reg <= `RX_ZERO;
        mem_wdata_reg <= `RX_ZERO;
    end else begin
        list_reg <= list_next;
        addr_reg <= addr_next;
        if (take) begin
            lsm_ld_reg <= (ex_class == RX_CL_LDM);
            wback_reg <= ex_wback;
            base_reg <= ex_rn;
        end
        mem_req_reg <= (st_next == RX_ST_LSM) && (list_next != 16'h0000);
        mem_we_reg <= (st_next == RX_ST_LSM) && (take ? (ex_class == RX_CL_STM) : !lsm_ld_reg);
        mem_addr_reg <= addr_next & `RX_WMASK;
        mem_wdata_reg <= st_val;
    end
end

endmodule

// ===== rx_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// memory partner: read data is address xor key
// ----------------------------------------
module rx_mem_model (
    input wire logic ref_clk,
    input wire logic mem_req_reg,
    input wire logic mem_we_reg,
    input wire logic [31:0] mem_addr_reg,
    input wire logic [31:0] mem_wdata_reg,
    input wire logic [31:0] key,
    input wire logic slow,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] wr [16];
    logic wait_reg;
    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0000_0000;
        wait_reg = 1'b0;
    end
    // ack drops after every word, so the core never sees a stale accept
    always @(posedge ref_clk) begin
        wait_reg <= ~wait_reg;
        mem_ack <= mem_req_reg && !mem_ack && !(slow && wait_reg);
        mem_rdata <= (mem_req_reg && !mem_ack) ? mem_addr_reg ^ key : ~mem_rdata;
        if (mem_req_reg && mem_ack && mem_we_reg) begin
            wr[mem_addr_reg[5:2]] <= mem_wdata_reg;
        end
    end
endmodule

// ===== rx_core_exec_assertions.sv
`timescale 1ns/1ps
module rx_core_exec_assertions
    import rx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ex_valid,
    input wire rx_class_e ex_class,
    input wire rx_cond_e ex_cond,
    input wire logic ex_mul_long,
    input wire logic ex_mul_acc,
    input wire logic irq_req,
    input wire logic fiq_req,
    input wire logic abort_req,
    input wire logic mem_ack,
    input wire logic ex_ready_reg,
    input wire logic ex_done_reg,
    input wire logic ex_skip_reg,
    input wire logic [31:0] program_counter_register,
    input wire rx_mode_e mode_reg,
    input wire logic compact_state_reg,
    input wire logic priv_reg,
    input wire logic mem_req_reg,
    input wire logic [31:0] mem_addr_reg
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic take;
    logic mul;
    assign take = ex_valid && ex_ready_reg && !abort_req && !fiq_req && !irq_req;
    assign mul = take && ex_class == RX_CL_MUL && ex_cond == RX_AL;
    reset_values_a: assert property (!$past(rst_n) |-> mode_reg == RX_MODE_SVC && program_counter_register == 32'h0000_0000)
        else $error("bad state after reset");
    priv_match_a: assert property (priv_reg == (mode_reg != RX_MODE_USR))
        else $error("privilege flag wrong");
    pc_align_a: assert property (!program_counter_register[0] && (compact_state_reg || !program_counter_register[1]))
        else $error("pc misaligned");
    alu_single_a: assert property (take && ex_class == RX_CL_ALU |=> ex_done_reg)
        else $error("alu op not done in one cycle");
    mul_plain_a: assert property (mul && !ex_mul_long && !ex_mul_acc |=> !ex_done_reg ##[1:4] ex_done_reg)
        else $error("plain multiply time wrong");
    mul_mid_a: assert property (mul && ex_mul_long != ex_mul_acc |=> !ex_done_reg [*2] ##[1:4] ex_done_reg)
        else $error("long or acc multiply time wrong");
    mul_long_acc_a: assert property (mul && ex_mul_long && ex_mul_acc |=> !ex_done_reg [*3] ##[1:4] ex_done_reg)
        else $error("long acc multiply time wrong");
    never_skip_a: assert property (take && ex_class == RX_CL_ALU && ex_cond == RX_NV |=> ex_done_reg && ex_skip_reg)
        else $error("never condition executed");
    mem_hold_a: assert property (mem_req_reg && !mem_ack && !abort_req |=> mem_req_reg && $stable(mem_addr_reg))
        else $error("memory request dropped before ack");
    abort_entry_a: assert property (ex_ready_reg && abort_req |=> mode_reg == RX_MODE_ABT)
        else $error("abort mode not entered");
    undef_entry_a: assert property (take && ex_class == RX_CL_UNDEF && ex_cond == RX_AL |=> mode_reg == RX_MODE_UND)
        else $error("undefined mode not entered");
endmodule
bind rx_core_exec rx_core_exec_assertions u_chk (.*);

// ===== rx_core_exec_tb.sv
`timescale 1ns/1ps
module rx_core_exec_tb
    import rx_pkg::*;
;
    logic ref_clk = 0, rst_n = 0, ex_valid = 0, ex_set_flags = 0, ex_mul_long = 0, ex_mul_acc = 0;
    logic ex_wback = 0, irq_req = 0, fiq_req = 0, abort_req = 0, slow = 0;
    logic ex_ready_reg, ex_done_reg, ex_skip_reg, compact_state_reg, priv_reg, mem_req_reg, mem_we_reg, mem_ack;
    rx_class_e ex_class = RX_CL_ALU;
    rx_cond_e ex_cond = RX_AL;
    rx_aluop_e ex_op = RX_MOV;
    rx_shift_e ex_sh_type = RX_SH_LSL;
    rx_mode_e ex_new_mode = RX_MODE_USR, mode_reg;
    logic [3:0] ex_rd = 0, ex_rn = 0, ex_rm = 0, ex_rs = 0, flags_reg;
    logic [4:0] ex_sh_amt = 0;
    logic [15:0] ex_reglist = 0;
    logic [31:0] key = 0, pc0, mem_rdata, program_counter_register, mem_addr_reg, mem_wdata_reg, e [4];
    rx_aluop_e ops [4] = '{RX_ADD, RX_SUB, RX_EOR, RX_BIC};
    rx_mode_e ml [5] = '{RX_MODE_IRQ, RX_MODE_ABT, RX_MODE_UND, RX_MODE_SVC, RX_MODE_FIQ};
    rx_mode_e xl [4] = '{RX_MODE_UND, RX_MODE_ABT, RX_MODE_FIQ, RX_MODE_IRQ};
    // pass pattern of each condition for flags n0 z1 c1 v0
    localparam logic [15:0] CMASK = 16'h66a5;
    int seed = 32'h1159_c858;
    int n_errors = 0, n_tests = 0, cyc, k, v;
    rx_core_exec uut (.*);
    rx_mem_model u_mem (.*);
    initial forever #4 ref_clk = ~ref_clk;
    initial begin
        #200_000;
        n_errors++;
        final_report();
    end
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function logic [31:0] alu(input rx_aluop_e o, input logic [31:0] a, input logic [31:0] b);
        case (o)
            RX_ADD: return a + b;
            RX_SUB: return a - b;
            RX_EOR: return a ^ b;
            default: return a & ~b;
        endcase
    endfunction
    function logic [31:0] shf(input rx_shift_e t, input logic [31:0] a, input logic [4:0] s);
        case (t)
            RX_SH_LSL: return a << s;
            RX_SH_LSR: return a >> s;
            RX_SH_ASR: return 32'($signed(a) >>> s);
            default: return (a >> s) | (a << (6'h20 - 6'(s)));
        endcase
    endfunction
    // ----------------------------------------
    // one instruction, cyc counts edges from take to done
    // ----------------------------------------
    task op(input rx_class_e c, input rx_aluop_e o, input int d, input int n, input int m, input int s);
        ex_class = c;
        ex_op = o;
        ex_rd = 4'(d);
        ex_rn = 4'(n);
        ex_rm = 4'(m);
        ex_rs = 4'(s);
        // an edge passes so valid never falls and rises in one step
        @(negedge ref_clk);
        repeat (99) if (ex_ready_reg !== 1'b1) @(negedge ref_clk);
        ex_valid = 1;
        @(negedge ref_clk);
        ex_valid = 0;
        for (cyc = 1; cyc < 99 && ex_done_reg !== 1'b1; cyc++) @(negedge ref_clk);
    endtask
    initial begin
        key = $random(seed) | 32'h8000_0000;
        repeat (8) @(negedge ref_clk);
        rst_n = 1;
        @(negedge ref_clk);
        chk({mode_reg, priv_reg, compact_state_reg, flags_reg, program_counter_register}, {RX_MODE_SVC, 6'h20, 32'h0000_0000});
        slow = 1;
        ex_reglist = 16'h001e;
        pc0 = program_counter_register;
        op(RX_CL_LDM, RX_MOV, 0, 0, 0, 0);
        chk(program_counter_register, pc0 + 32'h0000_0004);
        for (k = 0; k < 4; k++) begin
            ex_sh_amt = 5'($random(seed));
            ex_sh_type = rx_shift_e'(k);
            e[k] = alu(ops[k], key ^ 32'h0000_0004, shf(ex_sh_type, key ^ 32'h0000_0008, ex_sh_amt));
            op(RX_CL_ALU, ops[k], 5 + k, 2, 3, 0);
            chk(cyc, 1);
        end
        slow = 0;
        ex_reglist = 16'h01e0;
        op(RX_CL_STM, RX_MOV, 0, 0, 0, 0);
        for (k = 0; k < 4; k++) chk(u_mem.wr[k], e[k]);
        // rs keeps k nonzero bytes, so the multiply needs k steps
        ex_sh_type = RX_SH_LSR;
        for (k = 1; k < 5; k++) begin
            ex_sh_amt = 5'(32 - 8 * k);
            op(RX_CL_ALU, RX_MOV, 10, 0, 1, 0);
            for (v = 0; v < 4; v++) begin
                {ex_mul_acc, ex_mul_long} = 2'(v);
                op(RX_CL_MUL, RX_MOV, 11, 12, 2, 10);
                chk(cyc, 1 + k + v[0] + v[1]);
            end
        end
        {ex_mul_acc, ex_mul_long} = 2'b00;
        op(RX_CL_MUL, RX_MOV, 11, 12, 2, 1);
        ex_reglist = 16'h0800;
        op(RX_CL_STM, RX_MOV, 0, 0, 0, 0);
        chk(u_mem.wr[0], 32'((key ^ 32'h0000_0004) * key));
        ex_set_flags = 1;
        op(RX_CL_ALU, RX_CMP, 0, 1, 1, 0);
        ex_set_flags = 0;
        chk(flags_reg, 4'h6);
        for (k = 0; k < 16; k++) begin
            ex_cond = rx_cond_e'(k);
            op(RX_CL_ALU, RX_ADD, 7, 1, 1, 0);
            chk({cyc[3:0], ex_skip_reg}, {4'h1, ~CMASK[k]});
        end
        ex_cond = RX_AL;
        ex_sh_amt = 5'h1f;
        op(RX_CL_ALU, RX_MOV, 9, 0, 1, 0);
        ex_sh_amt = 0;
        for (k = 0; k < 2; k++) begin
            op(RX_CL_STATE, RX_MOV, 0, 0, k ? 0 : 9, 0);
            pc0 = program_counter_register;
            op(RX_CL_ALU, RX_MOV, 7, 0, 0, 0);
            chk({compact_state_reg, program_counter_register}, {~k[0], pc0 + (k ? 32'h0000_0004 : 32'h0000_0002)});
        end
        for (k = 0; k < 7; k++) begin
            ex_new_mode = k < 5 ? ml[k] : (k < 6 ? RX_MODE_USR : RX_MODE_SVC);
            op(RX_CL_MODE, RX_MOV, 0, 0, 0, 0);
            chk({mode_reg, priv_reg}, k < 5 ? {ml[k], 1'b1} : {RX_MODE_USR, 1'b0});
            if (k == 4) begin
                op(RX_CL_ALU, RX_MOV, 8, 0, 1, 0);
                ex_reglist = 16'h0100;
                op(RX_CL_STM, RX_MOV, 0, 0, 0, 0);
                chk(u_mem.wr[0], key);
                ex_new_mode = RX_MODE_SYS;
                op(RX_CL_MODE, RX_MOV, 0, 0, 0, 0);
                op(RX_CL_STM, RX_MOV, 0, 0, 0, 0);
                chk(u_mem.wr[0], e[3]);
            end
        end
        // base written back after one word, so the second store lands one word up
        ex_wback = 1;
        repeat (2) op(RX_CL_STM, RX_MOV, 0, 0, 0, 0);
        chk(u_mem.wr[1], e[3]);
        ex_class = RX_CL_UNDEF;
        for (k = 0; k < 4; k++) begin
            @(negedge ref_clk);
            {ex_valid, abort_req, fiq_req, irq_req} = 4'b1000 >> k;
            @(negedge ref_clk);
            {ex_valid, abort_req, fiq_req, irq_req} = 4'h0;
            chk({mode_reg, priv_reg}, {xl[k], 1'b1});
        end
        final_report();
    end
endmodule
